/* design/pmu_pkg.sv */
package pmu_pkg;

   // system make-up: probe is device 0, I/O modules are devices 1 to 4
   localparam int NDEV  = 5;
   localparam int NSIDE = 2;
   localparam int NPIN  = 2;
   localparam int NSTIM = (NDEV - 1) * NSIDE * NPIN;
   localparam int NCH   = 1 + NSTIM;

   // timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int FREERUN_HZ    = 1_000;
   localparam int FREERUN_CYC   = CLK_HZ / FREERUN_HZ;
   localparam int FREQ_GATE_S   = 1;
   localparam int FREQ_GATE_CYC = CLK_HZ * FREQ_GATE_S;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STROBE = 8'h04;
   localparam logic [7:0] ADDR_CFG0   = 8'h08;
   localparam logic [7:0] ADDR_SEL    = 8'h1C;
   localparam logic [7:0] ADDR_SIG    = 8'h20;
   localparam logic [7:0] ADDR_LVL    = 8'h24;
   localparam logic [7:0] ADDR_CNT    = 8'h28;
   localparam logic [7:0] ADDR_STIM   = 8'h2C;
   localparam logic [7:0] ADDR_STAT   = 8'h30;

   // field positions
   localparam int CTRL_ARM        = 0;
   localparam int CTRL_CLOSE      = 1;
   localparam int CFG_SRC_LSB     = 0;
   localparam int CFG_FREQ_BIT    = 2;
   localparam int CFG_ASYNC_BIT   = 3;
   localparam int CFG_DLY_LSB     = 4;
   localparam int DLY_W           = 4;
   localparam int CFG_START_RISE  = 8;
   localparam int CFG_STOP_RISE   = 9;
   localparam int CFG_CLK_RISE    = 10;
   localparam int CFG_EN_LSB      = 11;
   localparam int CFG_STOPCNT_BIT = 13;
   localparam int CFG_PULSER_BIT  = 14;
   localparam int CFG_SCNT_LSB    = 16;
   localparam int SCNT_W          = 16;
   localparam int SEL_DEV_LSB     = 0;
   localparam int SEL_SIDE_BIT    = 4;
   localparam int SEL_PIN_LSB     = 8;
   localparam int STIM_OE_LSB     = 16;
   localparam int STAT_WIN        = 0;
   localparam int STAT_DONE_LSB   = 8;
   localparam int CNT_OVF_BIT     = 31;

   // reset values
   localparam logic [31:0] CFG_RST  = 32'h0000_0000;
   localparam logic [31:0] SEL_RST  = 32'h0000_0100;
   localparam logic [31:0] STIM_RST = 32'h0000_0000;

   // pin selector limits
   localparam logic [7:0] PIN_MIN = 8'h01;
   localparam logic [7:0] PIN_MAX = 8'hFF;

   // one-hot pin class, bit weights equal the level-history weights
   localparam logic [2:0] CLS_LOW  = 3'h1;
   localparam logic [2:0] CLS_INV  = 3'h2;
   localparam logic [2:0] CLS_HIGH = 3'h4;

   // signature: x^16 + x^12 + x^9 + x^7 + 1
   localparam int          SIG_W    = 16;
   localparam logic [15:0] SIG_TAPS = 16'h8940;

   // external enable modes
   localparam logic [1:0] EN_HIGH = 2'h1;
   localparam logic [1:0] EN_LOW  = 2'h2;

   // positions in the synchronised input vector
   localparam int IN_PLO = 0;
   localparam int IN_PHI = 1;
   localparam int IN_MLO = 2;
   localparam int IN_MHI = IN_MLO + NSTIM;
   localparam int IN_XST = IN_MHI + NSTIM;
   localparam int IN_XSP = IN_XST + NDEV;
   localparam int IN_XCK = IN_XSP + NDEV;
   localparam int IN_XEN = IN_XCK + NDEV;
   localparam int IN_POD = IN_XEN + NDEV;
   localparam int IN_W   = IN_POD + 1;

   typedef enum logic [1:0] {
      SRC_POD  = 2'h0,
      SRC_INT  = 2'h1,
      SRC_EXT  = 2'h2,
      SRC_FREE = 2'h3
   } pmu_src_t;

   typedef enum logic [2:0] {
      EXT_WAIT = 3'b001,
      EXT_RUN  = 3'b010,
      EXT_DONE = 3'b100
   } pmu_ext_t;

endpackage

/* design/pmu_sync2ff.sv */
`timescale 1ns/1ps
module pmu_sync2ff
   import pmu_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

/* design/pmu_chan.sv */
`timescale 1ns/1ps
module pmu_chan
   import pmu_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // control
   input  wire logic             clr,
   input  wire logic             win,
   input  wire logic             sample,
   input  wire logic             async_mode,
   input  wire logic             freq_mode,
   input  wire logic             gate,
   input  wire logic [2:0]       cls,
   // results
   output logic      [SIG_W-1:0] sig_q,
   output logic      [2:0]       lvl_q,
   output logic      [31:0]      cnt_q
);

   logic [2:0] cls_q;
   logic       rise;
   logic       cnt_en;

   assign rise   = cls_q[1] & cls[2];
   assign cnt_en = win & rise & (~freq_mode | gate);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cls_q <= CLS_LOW;
      end else if (ce) begin
         cls_q <= cls;
      end
   end

   // weights fall out of the one-hot class code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q <= 3'h0;
      end else if (ce) begin
         if (clr) begin
            lvl_q <= (win && (async_mode || sample)) ? cls : 3'h0;
         end else if (win && (async_mode || sample)) begin
            lvl_q <= lvl_q | cls;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_q <= 16'h0000;
      end else if (ce) begin
         if (clr) begin
            sig_q <= 16'h0000;
         end else if (win && sample) begin
            sig_q <= {sig_q[SIG_W-2:0], (^(sig_q & SIG_TAPS)) ^ cls[2]};
         end
      end
   end

   // overflow stays set in the top bit while the low bits wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         if (clr) begin
            cnt_q <= 32'h0000_0000;
         end else if (cnt_en) begin
            cnt_q <= {cnt_q[CNT_OVF_BIT] | (&cnt_q[30:0]), cnt_q[30:0] + 31'h1};
         end
      end
   end

endmodule

/* design/pmu_top.sv */
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module pmu_top
   import pmu_pkg::*;
#(
   parameter int unsigned FREERUN_CYCLES = FREERUN_CYC,
   parameter int unsigned GATE_CYCLES    = FREQ_GATE_CYC
) (
   // clock, reset, enable
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic [7:0]       paddr,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // comparator outputs: above low threshold, above high threshold
   input  wire logic             probe_above_lo,
   input  wire logic             probe_above_hi,
   input  wire logic [NSTIM-1:0] mod_above_lo,
   input  wire logic [NSTIM-1:0] mod_above_hi,
   // external sync leads, one per device
   input  wire logic [NDEV-1:0]  ext_start,
   input  wire logic [NDEV-1:0]  ext_stop,
   input  wire logic [NDEV-1:0]  ext_clk,
   input  wire logic [NDEV-1:0]  ext_en,
   // pod access strobe
   input  wire logic             access_cycle_strobe_n,
   // stimulus
   output logic                  probe_stim,
   output logic                  probe_stim_oe,
   output logic      [NSTIM-1:0] mod_stim,
   output logic      [NSTIM-1:0] mod_stim_oe
);

   logic [IN_W-1:0]     raw;
   logic [IN_W-1:0]     syn;
   logic [NCH-1:0]      lo_v;
   logic [NCH-1:0]      hi_v;
   logic [2:0]          cls [NCH];
   logic                pod_prev_q;
   logic                pod_fall;
   logic [3*NDEV-1:0]   ext_prev_q;
   logic                win_q;
   logic                clr_q;
   logic [31:0]         cfg_q [NDEV];
   logic [NDEV-1:0]     freq_q;
   logic [NDEV-1:0]     stb_q;
   logic [31:0]         sel_q;
   logic [31:0]         stim_q;
   logic [31:0]         gate_cnt_q;
   logic                gate_q;
   logic [31:0]         free_cnt_q;
   logic                free_tick;
   logic [NDEV-1:0]     evt_v;
   logic [NDEV-1:0]     samp_v;
   logic [NDEV-1:0]     done_v;
   logic [SIG_W-1:0]    sig_a [NCH];
   logic [2:0]          lvl_a [NCH];
   logic [31:0]         cnt_a [NCH];
   logic                wr;
   logic                rd_setup;
   logic                cfg_hit;
   logic [2:0]          cfg_idx;
   logic                res_addr;
   logic                map_ok;
   logic [2:0]          sel_dev;
   logic                sel_side;
   logic [7:0]          sel_pin;
   logic                sel_ok;
   logic                ch_hit;
   int                  ch_idx;
   logic [31:0]         rd_d;

   function automatic logic edge_of(input logic rise_sel, input logic prv, input logic cur);
      return rise_sel ? (~prv & cur) : (prv & ~cur);
   endfunction

   // every pin and lead crosses into pclk through two flops; the strobe enters
   // inverted so the flops' reset level is its idle level and no false edge follows reset
   assign raw = {~access_cycle_strobe_n, ext_en, ext_clk, ext_stop, ext_start,
                 mod_above_hi, mod_above_lo, probe_above_hi, probe_above_lo};

   pmu_sync2ff #(
      .W (IN_W)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (raw),
      .q       (syn)
   );

   assign lo_v = {syn[IN_MLO +: NSTIM], syn[IN_PLO]};
   assign hi_v = {syn[IN_MHI +: NSTIM], syn[IN_PHI]};

   for (genvar c = 0; c < NCH; c++) begin : g_cls
      assign cls[c] = (lo_v[c] & hi_v[c])   ? CLS_HIGH :
                      (~lo_v[c] & ~hi_v[c]) ? CLS_LOW  : CLS_INV;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pod_prev_q <= 1'b0;
         ext_prev_q <= '0;
      end else if (ce) begin
         pod_prev_q <= syn[IN_POD];
         ext_prev_q <= syn[IN_XST +: 3*NDEV];
      end
   end

   assign pod_fall = ~pod_prev_q & syn[IN_POD];

   // apb: zero wait states while enabled, read data caught in the setup cycle
   assign wr       = psel & penable & pwrite & ce;
   assign rd_setup = psel & ~penable & ~pwrite & ce;
   assign pready   = ce;
   assign cfg_hit  = (paddr >= ADDR_CFG0) && (paddr < ADDR_SEL) && (paddr[1:0] == 2'h0);
   assign cfg_idx  = 3'((paddr - ADDR_CFG0) >> 2);
   assign res_addr = (paddr == ADDR_SIG) || (paddr == ADDR_LVL) || (paddr == ADDR_CNT);

   assign sel_dev  = sel_q[SEL_DEV_LSB +: 3];
   assign sel_side = sel_q[SEL_SIDE_BIT];
   assign sel_pin  = sel_q[SEL_PIN_LSB +: 8];
   assign sel_ok   = (sel_pin >= PIN_MIN) && (sel_pin <= PIN_MAX)
                     && (sel_dev < 3'(NDEV));

   always_comb begin
      map_ok = cfg_hit;
      unique case (paddr)
         ADDR_CTRL, ADDR_STROBE, ADDR_SEL, ADDR_STIM, ADDR_STAT: map_ok = 1'b1;
         ADDR_SIG, ADDR_LVL, ADDR_CNT:                           map_ok = 1'b1;
         default:                                                map_ok = cfg_hit;
      endcase
   end

   // result reads with a refused pin selector end in an error
   assign pslverr = psel & penable & ce & (~map_ok | (res_addr & ~pwrite & ~sel_ok));

   // pins past the clip width select nothing and read zero
   always_comb begin
      ch_hit = 1'b0;
      ch_idx = 0;
      if (sel_dev == 3'h0) begin
         ch_hit = (sel_pin == PIN_MIN) && !sel_side;
      end else if (sel_dev < 3'(NDEV)) begin
         ch_hit = (sel_pin >= PIN_MIN) && (sel_pin <= 8'(NPIN));
         if (ch_hit) begin
            ch_idx = 1 + ((int'(sel_dev) - 1) * NSIDE + int'(sel_side)) * NPIN
                     + int'(sel_pin) - 1;
         end
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      if (cfg_hit) begin
         rd_d = cfg_q[cfg_idx];
      end else begin
         unique case (paddr)
            ADDR_SEL:  rd_d = sel_q;
            ADDR_STIM: rd_d = stim_q;
            ADDR_STAT: begin
               rd_d[STAT_WIN] = win_q;
               rd_d[STAT_DONE_LSB +: NDEV] = done_v;
            end
            ADDR_SIG:  rd_d = ch_hit ? {16'h0000, sig_a[ch_idx]} : 32'h0000_0000;
            ADDR_LVL:  rd_d = ch_hit ? {29'h0000_0000, lvl_a[ch_idx]} : 32'h0000_0000;
            ADDR_CNT:  rd_d = ch_hit ? cnt_a[ch_idx] : 32'h0000_0000;
            default:   rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_d;
      end
   end

   // window control; a close in the same write as an arm wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q  <= 1'b0;
         clr_q  <= 1'b0;
         freq_q <= '0;
      end else if (ce) begin
         clr_q <= 1'b0;
         if (wr && paddr == ADDR_CTRL) begin
            if (pwdata[CTRL_CLOSE]) begin
               win_q <= 1'b0;
            end else if (pwdata[CTRL_ARM]) begin
               win_q <= 1'b1;
               clr_q <= 1'b1;
               for (int d = 0; d < NDEV; d++) begin
                  freq_q[d] <= cfg_q[d][CFG_FREQ_BIT];
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int d = 0; d < NDEV; d++) begin
            cfg_q[d] <= CFG_RST;
         end
      end else if (ce && wr && cfg_hit) begin
         cfg_q[cfg_idx] <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q  <= SEL_RST;
         stim_q <= STIM_RST;
         stb_q  <= '0;
      end else if (ce) begin
         stb_q <= (wr && paddr == ADDR_STROBE) ? pwdata[NDEV-1:0] : '0;
         if (wr && paddr == ADDR_SEL) begin
            sel_q <= pwdata;
         end
         if (wr && paddr == ADDR_STIM) begin
            stim_q <= pwdata;
         end
      end
   end

   // one gate from window open; edges counted inside it are hertz
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_cnt_q <= 32'h0000_0000;
         gate_q     <= 1'b0;
      end else if (ce) begin
         if (clr_q) begin
            gate_cnt_q <= 32'h0000_0000;
            gate_q     <= 1'b1;
         end else if (gate_q && win_q) begin
            gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
            if (gate_cnt_q == 32'(GATE_CYCLES - 1)) begin
               gate_q <= 1'b0;
            end
         end
      end
   end

   assign free_tick = (free_cnt_q == 32'(FREERUN_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         free_cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         free_cnt_q <= free_tick ? 32'h0000_0000 : free_cnt_q + 32'h0000_0001;
      end
   end

   for (genvar d = 0; d < NDEV; d++) begin : g_dev
      logic [31:0]       c;
      pmu_src_t          src;
      logic              st_e;
      logic              sp_e;
      logic              ck_e;
      logic              en_ok;
      logic              stop_now;
      logic              evt;
      pmu_ext_t          ext_q;
      logic [SCNT_W-1:0] ecnt_q;
      logic [DLY_W-1:0]  dly_q;
      logic              pend_q;
      logic              samp_q;

      assign c     = cfg_q[d];
      assign src   = pmu_src_t'(c[CFG_SRC_LSB +: 2]);
      assign st_e  = edge_of(c[CFG_START_RISE], ext_prev_q[d], syn[IN_XST+d]);
      assign sp_e  = edge_of(c[CFG_STOP_RISE], ext_prev_q[NDEV+d], syn[IN_XSP+d]);
      assign ck_e  = edge_of(c[CFG_CLK_RISE], ext_prev_q[2*NDEV+d], syn[IN_XCK+d]);
      assign en_ok = (c[CFG_EN_LSB +: 2] == EN_HIGH) ? syn[IN_XEN+d] :
                     (c[CFG_EN_LSB +: 2] == EN_LOW)  ? ~syn[IN_XEN+d] : 1'b1;
      assign stop_now = c[CFG_STOPCNT_BIT]
                        ? (ck_e & en_ok & ((ecnt_q + 16'h0001) == c[CFG_SCNT_LSB +: SCNT_W]))
                        : sp_e;

      always_comb begin
         unique case (src)
            SRC_POD:  evt = pod_fall;
            SRC_INT:  evt = stb_q[d];
            SRC_EXT:  evt = ck_e & en_ok & (ext_q == EXT_RUN);
            SRC_FREE: evt = free_tick;
         endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ext_q  <= EXT_WAIT;
            ecnt_q <= 16'h0000;
         end else if (ce) begin
            if (clr_q) begin
               ext_q  <= EXT_WAIT;
               ecnt_q <= 16'h0000;
            end else if (win_q && src == SRC_EXT) begin
               unique case (ext_q)
                  EXT_WAIT: begin
                     if (st_e) begin
                        ext_q <= EXT_RUN;
                     end
                  end
                  EXT_RUN: begin
                     if (ck_e && en_ok) begin
                        ecnt_q <= ecnt_q + 16'h0001;
                     end
                     if (stop_now) begin
                        ext_q <= EXT_DONE;
                     end
                  end
                  EXT_DONE: ext_q <= EXT_DONE;
                  default:  ext_q <= EXT_WAIT;
               endcase
            end
         end
      end

      // an edge that lands while a delayed sample is pending is dropped
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dly_q  <= 4'h0;
            pend_q <= 1'b0;
            samp_q <= 1'b0;
         end else if (ce) begin
            samp_q <= 1'b0;
            if (pend_q) begin
               dly_q <= dly_q - 4'h1;
               if (dly_q == 4'h1) begin
                  samp_q <= 1'b1;
                  pend_q <= 1'b0;
               end
            end else if (evt) begin
               if (c[CFG_DLY_LSB +: DLY_W] == 4'h0) begin
                  samp_q <= 1'b1;
               end else begin
                  pend_q <= 1'b1;
                  dly_q  <= c[CFG_DLY_LSB +: DLY_W];
               end
            end
         end
      end

      assign evt_v[d]  = evt;
      assign samp_v[d] = samp_q;
      assign done_v[d] = (ext_q == EXT_DONE);
   end

   for (genvar c = 0; c < NCH; c++) begin : g_chan
      localparam int D = (c == 0) ? 0 : 1 + (c - 1) / (NSIDE * NPIN);

      pmu_chan u_chan (
         .pclk       (pclk),
         .presetn    (presetn),
         .ce         (ce),
         .clr        (clr_q),
         .win        (win_q),
         .sample     (samp_v[D]),
         .async_mode (cfg_q[D][CFG_ASYNC_BIT]),
         .freq_mode  (freq_q[D]),
         .gate       (gate_q),
         .cls        (cls[c]),
         .sig_q      (sig_a[c]),
         .lvl_q      (lvl_a[c]),
         .cnt_q      (cnt_a[c])
      );
   end

   // probe pulser runs from the probe's sync event, window or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_stim <= 1'b0;
      end else if (ce && cfg_q[0][CFG_PULSER_BIT] && evt_v[0]) begin
         probe_stim <= ~probe_stim;
      end
   end

   assign probe_stim_oe = cfg_q[0][CFG_PULSER_BIT];
   assign mod_stim      = stim_q[NSTIM-1:0];
   assign mod_stim_oe   = stim_q[STIM_OE_LSB +: NSTIM];

endmodule

/* tb/pmu_chk.sv */
`timescale 1ns/1ps
module pmu_chk
   import pmu_pkg::*;
(
   // apb side
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             ce,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [7:0]       paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pslverr,
   // stimulus
   input wire logic             probe_stim,
   input wire logic             probe_stim_oe,
   input wire logic [NSTIM-1:0] mod_stim,
   input wire logic [NSTIM-1:0] mod_stim_oe
);
   logic       acc;
   logic       rdr;
   logic       wst;
   logic [7:0] pin_q;
   logic [2:0] dev_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc = psel && penable && ce;
   assign rdr = acc && !pwrite && (paddr == ADDR_SIG || paddr == ADDR_LVL || paddr == ADDR_CNT);
   assign wst = acc && pwrite && paddr == ADDR_STIM;
   // shadow of the selector, so that result reads can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= SEL_RST[15:8];
         dev_q <= SEL_RST[2:0];
      end else if (acc && pwrite && paddr == ADDR_SEL) begin
         pin_q <= pwdata[15:8];
         dev_q <= pwdata[2:0];
      end
   end
   property p_pin; rdr && pin_q == 8'h00 |-> pslverr; endproperty
   a_pin: assert property (p_pin) else $error("pin 0 read not refused");
   property p_dev; rdr && dev_q > 3'h4 |-> pslverr; endproperty
   a_dev: assert property (p_dev) else $error("missing device read not refused");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_lvl; acc && !pwrite && paddr == ADDR_LVL |-> prdata[31:3] == 29'h0; endproperty
   a_lvl: assert property (p_lvl) else $error("level code wider than 3 bits");
   property p_sig; acc && !pwrite && paddr == ADDR_SIG |-> prdata[31:16] == 16'h0; endproperty
   a_sig: assert property (p_sig) else $error("signature wider than 16 bits");
   property p_stim;
      wst |=> {mod_stim_oe, mod_stim} == $past(pwdata);
   endproperty
   a_stim: assert property (p_stim) else $error("module outputs not written");
   property p_hold; !wst |=> $stable(mod_stim) && $stable(mod_stim_oe); endproperty
   a_hold: assert property (p_hold) else $error("module outputs moved alone");
   property p_oe;
      acc && pwrite && paddr == ADDR_CFG0 |=> probe_stim_oe == $past(pwdata[CFG_PULSER_BIT]);
   endproperty
   a_oe: assert property (p_oe) else $error("pulser enable not taken");
   property p_pul; !probe_stim_oe |=> $stable(probe_stim); endproperty
   a_pul: assert property (p_pul) else $error("pulser moved while off");
   c_err: cover property (rdr && pslverr);
   c_sig: cover property (acc && !pwrite && paddr == ADDR_SIG && !pslverr);
   c_stim: cover property (wst);
endmodule
bind pmu_top pmu_chk i_pmu_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pslverr, .probe_stim, .probe_stim_oe, .mod_stim, .mod_stim_oe);

/* tb/pmu_pod.sv */
`timescale 1ns/1ps
module pmu_pod (
   // request
   input  wire logic       pclk,
   input  wire logic [1:0] lvl,
   input  wire logic       go,
   input  wire logic       data_ph,
   // to the block
   output logic            above_lo,
   output logic            above_hi,
   output logic            strobe_n
);
   logic [2:0] cnt_q = 3'h0;
   // lvl 0 low, 1 invalid, 2 high as seen by two thresholds
   assign above_lo = (lvl != 2'h0);
   assign above_hi = (lvl == 2'h2);
   // data phase holds the strobe longer than address phase
   always @(posedge pclk) begin
      if (go) begin
         cnt_q <= data_ph ? 3'h4 : 3'h2;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end
   assign strobe_n = (cnt_q == 3'h0);
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import pmu_pkg::*;
;
   localparam logic [32:0] F = 33'h1_FFFF_FFFF;
   localparam logic [32:0] ERR = 33'h1_0000_0000;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic go = 1'b0, dph = 1'b0, pready, pslverr, lo, hi, sn, ps, pso, b;
   logic [1:0]       lvl = 2'h0;
   logic [7:0]       paddr = 8'h00, r = 8'h4D;
   logic [15:0]      s;
   logic [31:0]      pwdata = 32'h0, prdata;
   logic [NSTIM-1:0] mlo = {NSTIM{1'b0}}, mhi = {NSTIM{1'b0}}, mst, moe;
   logic [NDEV-1:0]  xst = 5'h00, xsp = 5'h00, xck = 5'h00, xen = 5'h00;
   logic [32:0]      eq[$], mq[$];
   int               err_total = 0, comparisons = 0, cyc = 0, i;
   function automatic logic [7:0] nx(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic cy(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      eq.push_back(e);
      mq.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always #12.5 pclk = ~pclk;
   always #100 xck = ~xck;
   // free-running noise keeps the modules and external leads busy
   always @(posedge pclk) begin
      r <= nx(r);
      mlo <= {2{r}};
      mhi <= {2{~r}};
      {xst, xsp, xen} <= {r, r[6:0]};
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         end_of_test();
      end
   end
   // read data and error are taken at the edge that samples pready high
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         comparisons++;
         if ((({pslverr, prdata} ^ eq[0]) & mq[0]) !== 33'h0) begin
            err_total++;
            $display("[FAIL] %0t read at %h gave %h", $time, paddr, prdata);
         end
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
   end
   pmu_top #(.FREERUN_CYCLES(20), .GATE_CYCLES(200)) i_pmu_top (.pclk(pclk),
      .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .probe_above_lo(lo), .probe_above_hi(hi), .mod_above_lo(mlo), .mod_above_hi(mhi),
      .ext_start(xst), .ext_stop(xsp), .ext_clk(xck), .ext_en(xen),
      .access_cycle_strobe_n(sn), .probe_stim(ps), .probe_stim_oe(pso),
      .mod_stim(mst), .mod_stim_oe(moe));
   pmu_pod i_pmu_pod (.pclk(pclk), .lvl(lvl), .go(go), .data_ph(dph),
      .above_lo(lo), .above_hi(hi), .strobe_n(sn));
   initial begin
      cy(16);
      presetn <= 1'b1;
      rd(ADDR_SEL, {1'b0, SEL_RST}, F);
      rd(ADDR_CFG0, {1'b0, CFG_RST}, F);
      rd(ADDR_STIM, {1'b0, STIM_RST}, F);
      wr(ADDR_STIM, {r, nx(r), r, nx(r)});
      rd(8'h40, ERR, ERR);
      wr(ADDR_SEL, 32'h0);
      rd(ADDR_SIG, ERR, ERR);
      wr(ADDR_SEL, 32'h105);
      rd(ADDR_LVL, ERR, ERR);
      wr(ADDR_SEL, SEL_RST);
      wr(ADDR_CFG0, 32'h1);
      wr(ADDR_CTRL, 32'h1);
      for (i = 0; i < 3; i++) begin
         lvl <= i[1:0];
         cy(6);
         if (i != 1) wr(ADDR_STROBE, 32'h1);
         cy(6);
      end
      wr(ADDR_CTRL, 32'h2);
      rd(ADDR_LVL, {30'h0, CLS_LOW | CLS_HIGH}, F);
      wr(ADDR_CFG0, 32'h9);
      lvl <= 2'h0;
      cy(4);
      wr(ADDR_CTRL, 32'h1);
      lvl <= 2'h1;
      cy(1);
      lvl <= 2'h0;
      cy(6);
      wr(ADDR_CTRL, 32'h2);
      rd(ADDR_LVL, {30'h0, CLS_LOW | CLS_INV}, F);
      wr(ADDR_CFG0, 32'h1);
      wr(ADDR_CTRL, 32'h1);
      for (i = 0; i < 5; i++) begin
         if (i == 4) wr(ADDR_CTRL, 32'h2);
         lvl <= (i == 3) ? 2'h0 : 2'h1;
         cy(4);
         lvl <= 2'h2;
         cy(4);
      end
      rd(ADDR_CNT, {1'b0, 32'h3}, F);
      wr(ADDR_CFG0, 32'h4030);
      s = 16'h0;
      wr(ADDR_CTRL, 32'h1);
      for (i = 0; i < 6; i++) begin
         b = r[0];
         lvl <= b ? 2'h2 : 2'h0;
         dph <= i[0];
         cy(3);
         go <= 1'b1;
         cy(1);
         go <= 1'b0;
         cy(14);
         s = {s[14:0], ^(s & SIG_TAPS) ^ b};
      end
      wr(ADDR_CTRL, 32'h2);
      rd(ADDR_SIG, {17'h0, s}, F);
      wr(ADDR_CFG0, 32'h0002_2002);
      wr(ADDR_CTRL, 32'h1);
      cy(60);
      rd(ADDR_STAT, {1'b0, 32'h0000_0101}, F);
      wr(ADDR_CFG0, 32'h5);
      wr(ADDR_CTRL, 32'h1);
      for (i = 0; i < 6; i++) begin
         if (i == 3) cy(240);
         lvl <= 2'h1;
         cy(4);
         lvl <= 2'h2;
         cy(4);
      end
      wr(ADDR_CTRL, 32'h2);
      rd(ADDR_CNT, {1'b0, 32'h3}, F);
      end_of_test();
   end
endmodule
